/* design/arith_coproc_map.vh */
`ifndef ARITH_COPROC_MAP_VH
`define ARITH_COPROC_MAP_VH

// ********************************************************
// host i/o port offsets
// ********************************************************
`define STACK_PORT_ADDR 8'h10
`define CMD_STATUS_ADDR 8'h11
`define CONTROL_WORD_ADDR 8'ha0

// ********************************************************
// control word fields and reset values
// ********************************************************
`define CTRL_RESET_BIT 3
`define CTRL_RESET_VALUE 8'h00
`define INVALID_READ_DATA 8'hff
`define READ_DATA_RESET 8'h00

// ********************************************************
// operand fifo shape
// ********************************************************
`define FIFO_WIDTH 9
`define FIFO_DEPTH 32
`define FIFO_CMD_BIT 8

// ********************************************************
// timing
// ********************************************************
`define CLOCK_PERIOD_NS 50
`define WAIT_LIMIT_NS 15500
`define WAIT_LIMIT_CYCLES (`WAIT_LIMIT_NS / `CLOCK_PERIOD_NS)

`endif

/* design/operand_fifo.v */
`timescale 1ns/1ps

module operand_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire i_clock,
	input wire i_reset_n,
	input wire i_flush,
	input wire i_push_valid,
	output wire o_push_ready,
	input wire [WIDTH-1:0] i_push_data,
	output wire o_pop_valid,
	input wire i_pop_ready,
	output wire [WIDTH-1:0] o_pop_data
);

	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;

	localparam [31:0] DEPTH_W = DEPTH;
	localparam [AW:0] FULL_COUNT = DEPTH_W[AW:0];

	assign o_push_ready = (count_r != FULL_COUNT);
	assign o_pop_valid = (count_r != {(AW+1){1'b0}});
	assign o_pop_data = mem_r[rd_ptr_r];
	assign push = i_push_valid & o_push_ready;
	assign pop = o_pop_valid & i_pop_ready;

	always @(posedge i_clock) begin
		if (push) begin
			mem_r[wr_ptr_r] <= i_push_data;
		end
	end

	// flush drops everything queued for a coprocessor being reset
	always @(posedge i_clock) begin
		if (!i_reset_n || i_flush) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
			end
			if (push && !pop) begin
				count_r <= count_r + {{AW{1'b0}}, 1'b1};
			end else if (pop && !push) begin
				count_r <= count_r - {{AW{1'b0}}, 1'b1};
			end
		end
	end

endmodule // operand_fifo

/* design/wait_timer.v */
`timescale 1ns/1ps
`include "arith_coproc_map.vh"

module wait_timer (
	input wire i_clock,
	input wire i_reset_n,
	input wire i_run,
	output wire o_expired
);

	localparam integer LIMIT = `WAIT_LIMIT_CYCLES;
	localparam [31:0] LIMIT_M1 = LIMIT - 1;

	reg [8:0] count_r;

	// restarts whenever the bus cycle is not being stretched
	always @(posedge i_clock) begin
		if (!i_reset_n || !i_run) begin
			count_r <= 9'h000;
		end else if (!o_expired) begin
			count_r <= count_r + 9'h001;
		end
	end

	assign o_expired = i_run && (count_r == LIMIT_M1[8:0]);

endmodule // wait_timer

/* design/arith_coprocessor_port.v */
// What this block does
// - decode only stack, command/status and control word ports
// - command write starts the computation
// - results read from stack, high byte first
// - command port read returns coprocessor status
// - completion can raise an interrupt request
// - pause option stretches host cycles
// - early result read times out, data invalid
// - enabled service request drives line two
// - enabled end of operation drives line two
// - line two feeds trigger two with power-fail
// - power-up reset resets the coprocessor
// - control bit 3 low resets coprocessor
// - four-function variant does float arithmetic
// - full variant adds transcendental and conversion
// - wait stretch limited to 15.5 us
`timescale 1ns/1ps
`include "arith_coproc_map.vh"

module arith_coprocessor_port (
	input wire i_clock,
	input wire i_reset_n,
	// host i/o bus
	input wire [7:0] i_io_addr,
	input wire i_io_rd,
	input wire i_io_wr,
	input wire [7:0] i_io_wdata,
	output wire [7:0] o_io_rdata,
	output wire o_io_wait,
	// coprocessor write side
	output wire o_cp_wr_valid,
	input wire i_cp_wr_ready,
	output wire o_cp_wr_cmd,
	output wire [7:0] o_cp_wr_data,
	// coprocessor read side
	output wire o_cp_rd_req,
	output wire o_cp_rd_cmd,
	input wire i_cp_rd_valid,
	input wire [7:0] i_cp_rd_data,
	// coprocessor control and events
	output wire o_cp_reset_n,
	input wire i_cp_pause,
	input wire i_cp_end,
	input wire i_cp_service_request,
	// option jumper block
	input wire i_opt_pause_en,
	input wire i_opt_service_request_en,
	input wire i_opt_end_en,
	// system side
	input wire i_power_fail,
	output wire [7:0] o_control_word,
	output wire o_interrupt_line_two,
	output wire o_trigger_two
);

	// ********************************************************
	// states
	// ********************************************************
	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_WRITE = 5'b00010;
	localparam [4:0] ST_RD_QUEUE = 5'b00100;
	localparam [4:0] ST_RD_WAIT = 5'b01000;
	localparam [4:0] ST_DONE = 5'b10000;

	reg [4:0] state_r;
	reg [4:0] state_nxt;
	reg [7:0] control_r;
	reg [7:0] control_nxt;
	reg [7:0] rdata_r;
	reg [7:0] rdata_nxt;
	reg rd_cmd_r;
	reg rd_cmd_nxt;
	reg cp_reset_n_r;
	reg irq_two_r;
	reg trigger_two_r;
	reg push_valid;
	reg rd_req;
	reg cp_reset_n_nxt;
	reg irq_two_nxt;
	reg trigger_two_nxt;
	reg rd_stale_r;
	reg rd_stale_nxt;

	wire sel_stack;
	wire sel_cmd;
	wire sel_ctrl;
	wire sel_coproc;
	wire paused;
	wire stretching;
	wire timed_out;
	wire push_ready;
	wire pop_valid;
	wire [8:0] pop_data;
	wire [8:0] push_data;

	// ********************************************************
	// address decode
	// ********************************************************
	// exact match: the rest of the 10h block is left unanswered
	assign sel_stack = (i_io_addr == `STACK_PORT_ADDR);
	assign sel_cmd = (i_io_addr == `CMD_STATUS_ADDR);
	assign sel_ctrl = (i_io_addr == `CONTROL_WORD_ADDR);
	assign sel_coproc = sel_stack | sel_cmd;

	// ********************************************************
	// wait logic
	// ********************************************************
	assign paused = i_opt_pause_en & i_cp_pause;
	assign stretching = (state_r == ST_WRITE) ||
		(state_r == ST_RD_QUEUE) || (state_r == ST_RD_WAIT);
	assign o_io_wait = stretching;

	wait_timer u_wait_timer (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_run(stretching),
		.o_expired(timed_out)
	);

	// ********************************************************
	// operand and command queue
	// ********************************************************
	// commands share the queue so they can never overtake operands
	assign push_data = {sel_cmd, i_io_wdata};

	operand_fifo #(
		.WIDTH(`FIFO_WIDTH),
		.DEPTH(`FIFO_DEPTH),
		.AW(5)
	) u_operand_fifo (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_flush(!cp_reset_n_r),
		.i_push_valid(push_valid),
		.o_push_ready(push_ready),
		.i_push_data(push_data),
		.o_pop_valid(pop_valid),
		.i_pop_ready(i_cp_wr_ready & cp_reset_n_r),
		.o_pop_data(pop_data)
	);

	// op code goes through unchanged; the engine does the arithmetic
	assign o_cp_wr_valid = pop_valid & cp_reset_n_r;
	assign o_cp_wr_cmd = pop_data[`FIFO_CMD_BIT];
	assign o_cp_wr_data = pop_data[7:0];

	// ********************************************************
	// host access sequencer
	// ********************************************************
	always @* begin
		state_nxt = state_r;
		control_nxt = control_r;
		rdata_nxt = rdata_r;
		rd_cmd_nxt = rd_cmd_r;
		push_valid = 1'b0;
		rd_req = 1'b0;
		case (state_r)
		ST_IDLE: begin
			if (i_io_wr && sel_coproc) begin
				state_nxt = ST_WRITE;
			end else if (i_io_rd && sel_coproc) begin
				rd_cmd_nxt = sel_cmd;
				state_nxt = ST_RD_QUEUE;
			end else if (i_io_wr && sel_ctrl) begin
				// write-only: a read here is not answered
				control_nxt = i_io_wdata;
				state_nxt = ST_DONE;
			end
		end
		ST_WRITE: begin
			if (timed_out) begin
				state_nxt = ST_DONE;
			end else if (push_ready && !paused) begin
				push_valid = 1'b1;
				state_nxt = ST_DONE;
			end
		end
		ST_RD_QUEUE: begin
			// queued bytes must reach the engine before any read
			if (timed_out) begin
				rdata_nxt = `INVALID_READ_DATA;
				state_nxt = ST_DONE;
			end else if (!pop_valid && !paused && cp_reset_n_r &&
				!rd_stale_r) begin
				rd_req = 1'b1;
				state_nxt = ST_RD_WAIT;
			end
		end
		ST_RD_WAIT: begin
			if (i_cp_rd_valid) begin
				rdata_nxt = i_cp_rd_data;
				state_nxt = ST_DONE;
			end else if (timed_out) begin
				// the timeout overrides a still-busy engine
				rdata_nxt = `INVALID_READ_DATA;
				state_nxt = ST_DONE;
			end
		end
		ST_DONE: begin
			if (!i_io_rd && !i_io_wr) begin
				state_nxt = ST_IDLE;
			end
		end
		default: begin
			state_nxt = ST_IDLE;
		end
		endcase
	end

	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			state_r <= ST_IDLE;
			control_r <= `CTRL_RESET_VALUE;
			rdata_r <= `READ_DATA_RESET;
			rd_cmd_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			control_r <= control_nxt;
			rdata_r <= rdata_nxt;
			rd_cmd_r <= rd_cmd_nxt;
		end
	end

	// ********************************************************
	// stale answer guard
	// ********************************************************
	// a read that timed out may still be answered later; hold
	// back the next request until that late answer has gone by,
	// so it can never be taken for the new one
	always @* begin
		rd_stale_nxt = rd_stale_r;
		if (!cp_reset_n_r || i_cp_rd_valid) begin
			rd_stale_nxt = 1'b0;
		end else if (state_r == ST_RD_WAIT && timed_out) begin
			rd_stale_nxt = 1'b1;
		end
	end

	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			rd_stale_r <= 1'b0;
		end else begin
			rd_stale_r <= rd_stale_nxt;
		end
	end

	// ********************************************************
	// host and coprocessor outputs
	// ********************************************************
	assign o_io_rdata = rdata_r;
	assign o_cp_rd_req = rd_req;
	assign o_cp_rd_cmd = rd_cmd_r;
	assign o_control_word = control_r;

	// ********************************************************
	// coprocessor reset
	// ********************************************************
	// hold time is software's job; no minimum is enforced here
	always @* begin
		cp_reset_n_nxt = control_nxt[`CTRL_RESET_BIT];
	end

	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			cp_reset_n_r <= 1'b0;
		end else begin
			cp_reset_n_r <= cp_reset_n_nxt;
		end
	end

	assign o_cp_reset_n = cp_reset_n_r;

	// ********************************************************
	// interrupt line two
	// ********************************************************
	// plain levels: the controller upstream does its own latching
	always @* begin
		irq_two_nxt = (i_opt_service_request_en & i_cp_service_request) |
			(i_opt_end_en & i_cp_end);
		// power fail shares the trigger input with line two
		trigger_two_nxt = irq_two_nxt | i_power_fail;
	end

	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			irq_two_r <= 1'b0;
			trigger_two_r <= 1'b0;
		end else begin
			irq_two_r <= irq_two_nxt;
			trigger_two_r <= trigger_two_nxt;
		end
	end

	assign o_interrupt_line_two = irq_two_r;
	assign o_trigger_two = trigger_two_r;

endmodule // arith_coprocessor_port

/* sim/arith_coproc_monitor.sv */
`timescale 1ns/1ps
module arith_coproc_monitor (
	input wire i_clock,
	input wire i_reset_n,
	input wire [7:0] i_io_addr,
	input wire i_io_rd,
	input wire i_io_wr,
	input wire [7:0] i_io_wdata,
	input wire o_io_wait,
	input wire o_cp_wr_valid,
	input wire i_cp_wr_ready,
	input wire o_cp_rd_req,
	input wire o_cp_reset_n,
	input wire i_cp_end,
	input wire i_cp_service_request,
	input wire i_opt_service_request_en,
	input wire i_opt_end_en,
	input wire i_power_fail,
	input wire [7:0] o_control_word,
	input wire o_interrupt_line_two,
	input wire o_trigger_two
);
	// ********************************
	// port protocol checks
	// ********************************
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	chk_reset_vals: assert property (disable iff (1'b0)
		!i_reset_n |=> !o_cp_reset_n && o_control_word == 8'h00 && !o_io_wait
		&& !o_interrupt_line_two) else $error("bad reset state");
	chk_port_wait: assert property (
		($rose(i_io_rd) || $rose(i_io_wr)) && i_io_addr[7:1] == 7'h08
		|=> o_io_wait) else $error("no wait on coprocessor port");
	chk_no_decode: assert property (
		($rose(i_io_rd) || $rose(i_io_wr)) && i_io_addr[7:1] != 7'h08
		|=> !o_io_wait) else $error("wait on foreign port");
	chk_wait_bound: assert property (
		$rose(o_io_wait) |-> ##[1:311] !o_io_wait) else $error("wait too long");
	chk_ctrl_write: assert property (
		$rose(i_io_wr) && i_io_addr == 8'ha0
		|-> ##2 o_control_word == $past(i_io_wdata, 2))
		else $error("control word not written");
	chk_cp_reset: assert property (
		$past(i_reset_n) && $stable(o_control_word)
		|-> o_cp_reset_n == o_control_word[3]) else $error("reset bit");
	chk_held_reset: assert property (
		!o_cp_reset_n |-> !o_cp_wr_valid) else $error("byte sent in reset");
	chk_read_drain: assert property (
		o_cp_rd_req |-> !o_cp_wr_valid) else $error("read before drain");
	chk_irq_or: assert property (
		$past(i_reset_n) |-> o_interrupt_line_two ==
		$past(i_cp_service_request & i_opt_service_request_en | i_cp_end & i_opt_end_en))
		else $error("line two wrong");
	chk_trig_two: assert property (
		$past(i_reset_n) && ($past(i_power_fail) ||
		o_interrupt_line_two && $past(o_interrupt_line_two))
		|-> o_trigger_two) else $error("trigger two low");
	cover property (o_cp_rd_req);
	cover property (o_cp_wr_valid && i_cp_wr_ready);
	cover property (o_trigger_two && !i_power_fail);
endmodule // arith_coproc_monitor

bind arith_coprocessor_port arith_coproc_monitor i_mon (
	.i_clock(i_clock),
	.i_reset_n(i_reset_n),
	.i_io_addr(i_io_addr),
	.i_io_rd(i_io_rd),
	.i_io_wr(i_io_wr),
	.i_io_wdata(i_io_wdata),
	.o_io_wait(o_io_wait),
	.o_cp_wr_valid(o_cp_wr_valid),
	.i_cp_wr_ready(i_cp_wr_ready),
	.o_cp_rd_req(o_cp_rd_req),
	.o_cp_reset_n(o_cp_reset_n),
	.i_cp_end(i_cp_end),
	.i_cp_service_request(i_cp_service_request),
	.i_opt_service_request_en(i_opt_service_request_en),
	.i_opt_end_en(i_opt_end_en),
	.i_power_fail(i_power_fail),
	.o_control_word(o_control_word),
	.o_interrupt_line_two(o_interrupt_line_two),
	.o_trigger_two(o_trigger_two)
);

/* sim/coproc_model.sv */
`timescale 1ns/1ps
module coproc_model (
	input wire i_clock,
	input wire i_rst_n,
	input wire i_stall,
	input wire i_wr_valid,
	input wire i_wr_cmd,
	input wire [7:0] i_wr_data,
	output logic o_wr_ready = 1'b0,
	input wire i_rd_req,
	input wire i_rd_cmd,
	output logic o_rd_valid = 1'b0,
	output logic [7:0] o_rd_data = 8'h00,
	output logic o_pause = 1'b0,
	output logic o_end = 1'b0
);
	// ********************************
	// behavioural coprocessor
	// ********************************
	logic [7:0] stk[$];
	int cnt_r;
	logic pend_r, pcmd_r;
	always @(posedge i_clock) begin
		o_rd_valid <= 1'b0;
		o_wr_ready <= !i_stall && ($urandom % 2);
		if (!i_rst_n) begin
			stk.delete();
			o_pause <= 1'b0;
			o_end <= 1'b0;
			pend_r <= 1'b0;
		end else begin
			if (i_wr_valid && o_wr_ready && i_wr_cmd) begin
				o_pause <= 1'b1;
				o_end <= 1'b0;
				cnt_r <= i_wr_data[7] ? 400 : 20;
			end else if (i_wr_valid && o_wr_ready) begin
				stk.push_back(i_wr_data);
			end else if (o_pause) begin
				cnt_r <= cnt_r - 1;
				o_pause <= cnt_r > 1;
				o_end <= cnt_r == 1;
			end
			pend_r <= i_rd_req;
			pcmd_r <= i_rd_cmd;
			// last pushed byte comes out first, so high byte leads
			if (pend_r) begin
				o_rd_valid <= 1'b1;
				o_rd_data <= pcmd_r ? {o_pause, 7'h00} : stk.pop_back();
			end else begin
				o_rd_data <= ~o_rd_data;
			end
		end
	end
endmodule // coproc_model

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
	// ********************************
	// stimulus and checks
	// ********************************
	logic i_clock = 0, i_reset_n = 0, i_io_rd = 0, i_io_wr = 0, stall = 0;
	logic [7:0] i_io_addr = 8'h00, i_io_wdata = 8'h00, q, ctl, ops[8];
	logic sv = 0, sven = 0, enden = 0, pf = 0, pen = 1;
	wire [7:0] rdata, wd, rd, cw;
	wire wt, wv, rdy, wcmd, rq, rcmd, rv, crst, pause, done, l2, t2;
	int error_cnt = 0, total_checks = 0, n, k, s;
	always #25 i_clock = ~i_clock;
	arith_coprocessor_port i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
		.i_io_addr(i_io_addr), .i_io_rd(i_io_rd), .i_io_wr(i_io_wr),
		.i_io_wdata(i_io_wdata), .o_io_rdata(rdata), .o_io_wait(wt),
		.o_cp_wr_valid(wv), .i_cp_wr_ready(rdy), .o_cp_wr_cmd(wcmd),
		.o_cp_wr_data(wd), .o_cp_rd_req(rq), .o_cp_rd_cmd(rcmd),
		.i_cp_rd_valid(rv), .i_cp_rd_data(rd), .o_cp_reset_n(crst),
		.i_cp_pause(pause), .i_cp_end(done), .i_cp_service_request(sv),
		.i_opt_pause_en(pen), .i_opt_service_request_en(sven), .i_opt_end_en(enden),
		.i_power_fail(pf), .o_control_word(cw), .o_interrupt_line_two(l2),
		.o_trigger_two(t2));
	coproc_model i_cp (.i_clock(i_clock), .i_rst_n(crst), .i_stall(stall),
		.i_wr_valid(wv), .i_wr_cmd(wcmd), .i_wr_data(wd), .o_wr_ready(rdy),
		.i_rd_req(rq), .i_rd_cmd(rcmd), .o_rd_valid(rv), .o_rd_data(rd),
		.o_pause(pause), .o_end(done));
	function [7:0] irq_exp(input logic a, b, e, d, p);
		irq_exp = {6'h00, (a & b | d & e) | p, a & b | d & e};
	endfunction
	task print_verdict;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input [7:0] e, input [7:0] v, input string nm);
		total_checks++;
		if (v !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, v);
		end
	endtask
	// strobe held until the wait is seen low; bound cuts a hang
	task io(input logic w, input [7:0] a, d, output [7:0] r, output int c);
		i_io_addr = a;
		i_io_wdata = d;
		i_io_wr = w;
		i_io_rd = !w;
		c = 0;
		repeat (2) @(negedge i_clock);
		while (wt !== 1'b0 && c < 400) begin
			c++;
			@(negedge i_clock);
		end
		if (c >= 400) begin
			error_cnt++;
			print_verdict;
		end
		r = rdata;
		i_io_wr = 0;
		i_io_rd = 0;
		@(negedge i_clock);
	endtask
	initial begin
		k = $urandom(32'h9920);
		repeat (20) @(negedge i_clock);
		i_reset_n = 1;
		chk(8'h00, cw, "ctrl reset");
		chk(8'h00, {7'h00, crst}, "cp reset");
		ctl = ($urandom & 8'hf7) | 8'h08;
		io(1, 8'ha0, ctl, q, n);
		chk(ctl, cw, "ctrl word");
		chk(8'h01, {7'h00, crst}, "cp run");
		io(0, 8'h12, 8'h00, q, n);
		chk(8'h00, 8'(n), "foreign wait");
		for (s = 2; s <= 8; s = s * 2) begin
			for (k = 0; k < s; k++) begin
				ops[k] = $urandom;
				io(1, 8'h10, ops[k], q, n);
			end
			io(1, 8'h11, 8'h01, q, n);
			io(0, 8'h11, 8'h00, q, n);
			chk(8'h00, q & 8'h80, "status");
			for (k = 0; k < s; k++) begin
				io(0, 8'h10, 8'h00, q, n);
				chk(ops[s - 1 - k], q, "result");
			end
		end
		io(1, 8'h11, 8'h80, q, n);
		io(0, 8'h10, 8'h00, q, n);
		chk(8'hff, q, "early read");
		chk(8'h01, 8'(n > 300), "read timeout");
		repeat (200) @(negedge i_clock);
		stall = 1;
		for (k = 0; k < 33; k++)
			io(1, 8'h10, 8'(k), q, n);
		chk(8'h01, 8'(n > 300), "full refuse");
		stall = 0;
		repeat (100) @(negedge i_clock);
		chk(8'h20, 8'(i_cp.stk.size()), "queued");
		io(1, 8'ha0, ctl & 8'hf7, q, n);
		repeat (1000) @(negedge i_clock);
		chk(8'h00, {7'h00, crst}, "sw reset");
		io(1, 8'ha0, ctl, q, n);
		chk(8'h00, 8'(i_cp.stk.size()), "flushed");
		pen = 0;
		io(1, 8'h11, 8'h81, q, n);
		io(0, 8'h11, 8'h00, q, n);
		chk(8'h80, q & 8'h80, "busy status");
		chk(8'h01, 8'(n < 300), "pause off");
		io(1, 8'h11, 8'h01, q, n);
		repeat (30) @(negedge i_clock);
		for (k = 0; k < 16; k++) begin
			{pf, sv, sven, enden} = 4'(k);
			repeat (2) @(negedge i_clock);
			chk(irq_exp(sv, sven, enden, done, pf), {6'h00, t2, l2},
				"irq");
		end
		print_verdict;
	end
endmodule // tb
